/* rtl/scdc_pkg.sv */
// constants and carriers of the segmented cache manager
package scdc_pkg;
   localparam int LBA_W     = 32;
   localparam int CNT_W     = 16;
   localparam int SEG_W     = 12;
   localparam int ADR_W     = 16;
   localparam int IDX_W     = 4;
   localparam int NSEG_MAX  = 16;
   localparam int BLK_BYTES = 512;
   localparam int BUF_SMALL = 434080;
   localparam int BUF_LARGE = 1915392;
   localparam int CYL_W     = 11;
   // register offsets
   localparam logic [3:0] A_CTRL  = 4'h0;
   localparam logic [3:0] A_AHEAD = 4'h1;
   localparam logic [3:0] A_NSEG  = 4'h2;
   localparam logic [3:0] A_MAXPF = 4'h3;
   localparam logic [3:0] A_SEGSZ = 4'h4;
   localparam logic [3:0] A_CHECK = 4'h5;
   localparam logic [3:0] A_STAT  = 4'h6;
   localparam logic [3:0] A_CHIT  = 4'h7;
   localparam logic [3:0] A_PHIT  = 4'h8;
   // field positions
   localparam int B_RCD  = 0;
   localparam int B_WCE  = 2;
   localparam int B_DISC = 4;
   localparam int B_DRA  = 5;
   localparam int B_CHK  = 1;
   localparam int B_REJ  = 0;
   localparam logic [15:0] CTRL_MASK  = 16'h0015;
   localparam logic [15:0] AHEAD_MASK = 16'h0020;
   localparam logic [15:0] CHECK_MASK = 16'h0002;
   // reset values
   localparam logic [15:0] CTRL_RST  = 16'h0000;
   localparam logic [15:0] AHEAD_RST = 16'h0000;
   localparam logic [15:0] CHECK_RST = 16'h0000;
   localparam logic [15:0] MAXPF_RST = 16'h0040;
   localparam logic [4:0]  NSEG_RST  = 5'h03;
   localparam logic [4:0]  NSEG_MIN  = 5'h01;
   localparam logic [4:0]  NSEG_TOP  = 5'h10;
   localparam logic [15:0] SEGSZ_RD  = 16'hffff;

   typedef enum logic [2:0] {
      S_IDLE  = 3'b000,
      S_HIT   = 3'b001,
      S_FETCH = 3'b011,
      S_PREF  = 3'b010,
      S_WINV  = 3'b110,
      S_WDATA = 3'b111
   } scdc_state_t;

   typedef struct packed {
      logic [LBA_W-1:0] lba;
      logic [CNT_W-1:0] nblk;
      logic             write;
      logic             dpo;
      logic             swi;
   } scdc_cmd_t;

   typedef struct packed {
      logic             valid;
      logic             hit;
      logic             pf_hit;
      logic             paced;
      logic [LBA_W-1:0] lba;
      logic [ADR_W-1:0] addr;
   } scdc_xfer_t;

   typedef struct packed {
      logic             rd;
      logic             wr;
      logic [LBA_W-1:0] lba;
      logic [ADR_W-1:0] addr;
   } scdc_med_t;
endpackage

/* rtl/scdc_cache.sv */
// segmented buffer cache manager: tags, hits, fetch, prefetch, write cache
// What this block does
// - segment count may be any integer from 1 to 16.
// - segment count is three after reset.
// - segment size is usable buffer divided by segment count.
// - host writes segment count register; buffer is repartitioned.
// - with read cache on, cached tags are searched before medium access.
// - with read cache off, medium is read; segments serve only prefetched blocks.
// - miss transfers are paced; hit transfers ignore pacing.
// - cached run is sent, then first uncached block and rest fetched.
// - first block uncached: all blocks read into one segment.
// - after a fetch, prefetch following blocks up to the maximum.
// - prefetch crosses cylinder only with discontinuity bit; resets zero.
// - each segment is circular, a whole number of sectors long.
// - segment size field always reads all ones.
// - size writes ignored; rejected when parameter check bit set.
// - write cache shares segments; segmentation ignores cache enables.
// - write cache enable resets to disabled.
// - write with dpo is not cached but still invalidates copies.
// - writes invalidate overlapping segments, then cache new data.
// - writes wrap in segment and stall before overwriting uncommitted.
// - prefetch on when read-ahead disable is 0; counts prefetch hits.
// - prefetch limited by maximum field; ceiling field ignored.
// - with interleave, look-ahead follows predicted hits.
// - without interleave, non-contiguous reads stop prefetch.
`timescale 1ns/100ps
module scdc_cache
#(
   parameter bit LARGE_BUF = 1'b0,
   parameter int CYL_W     = scdc_pkg::CYL_W
)
(
   input  wire logic                clk,
   input  wire logic                nrst,
   input  wire logic [3:0]          addr,
   input  wire logic [15:0]         wdata,
   input  wire logic                wr,
   input  wire logic                rd,
   output      logic [15:0]         rdata,
   input  wire logic                cmd_valid,
   input  wire scdc_pkg::scdc_cmd_t cmd,
   output      logic                cmd_ready,
   input  wire logic                wr_valid,
   output      logic                wr_ready,
   output      scdc_pkg::scdc_xfer_t xfer,
   output      scdc_pkg::scdc_med_t med,
   input  wire logic                med_ack
);
   localparam int LW = scdc_pkg::LBA_W;
   localparam int SW = scdc_pkg::SEG_W;
   localparam int AW = scdc_pkg::ADR_W;
   localparam int IW = scdc_pkg::IDX_W;
   localparam int NS = scdc_pkg::NSEG_MAX;
   localparam int BUF_BLK = (LARGE_BUF ? scdc_pkg::BUF_LARGE
                             : scdc_pkg::BUF_SMALL) / scdc_pkg::BLK_BYTES;

   ////////////////////////////////////////////////////////////////////////
   // registers
   logic [15:0] ctrl, ahead, check, maxpf, chit, phit;
   logic [4:0]  nseg;
   logic        rej;
   logic [15:0] next_ctrl, next_ahead, next_check, next_maxpf, next_rdata;
   logic [4:0]  next_nseg;
   logic        next_rej, nseg_wr, rcd, wce, disc, dra;

   assign rcd  = ctrl[scdc_pkg::B_RCD];
   assign wce  = ctrl[scdc_pkg::B_WCE];
   assign disc = ctrl[scdc_pkg::B_DISC];
   assign dra  = ahead[scdc_pkg::B_DRA];
   assign nseg_wr = wr && addr == scdc_pkg::A_NSEG
                    && wdata >= 16'(scdc_pkg::NSEG_MIN)
                    && wdata <= 16'(scdc_pkg::NSEG_TOP)
                    && wdata[4:0] != nseg;

   always_comb
   begin
      next_ctrl  = ctrl;
      next_ahead = ahead;
      next_check = check;
      next_maxpf = maxpf;
      next_nseg  = nseg;
      next_rej   = rej;
      next_rdata = 16'h0000;
      if (wr && addr == scdc_pkg::A_CTRL)
         next_ctrl = wdata & scdc_pkg::CTRL_MASK;
      else if (wr && addr == scdc_pkg::A_AHEAD)
         next_ahead = wdata & scdc_pkg::AHEAD_MASK;
      else if (nseg_wr)
         next_nseg = wdata[4:0];
      else if (wr && addr == scdc_pkg::A_MAXPF)
         next_maxpf = wdata;
      else if (wr && addr == scdc_pkg::A_CHECK)
         next_check = wdata & scdc_pkg::CHECK_MASK;
      else if (wr && addr == scdc_pkg::A_STAT && wdata[scdc_pkg::B_REJ])
         next_rej = 1'b0;
      // size writes never change segmentation
      if (wr && addr == scdc_pkg::A_SEGSZ && check[scdc_pkg::B_CHK])
         next_rej = 1'b1;
      if (rd)
      begin
         if (addr == scdc_pkg::A_CTRL)
            next_rdata = ctrl;
         else if (addr == scdc_pkg::A_AHEAD)
            next_rdata = ahead;
         else if (addr == scdc_pkg::A_NSEG)
            next_rdata = {11'h000, nseg};
         else if (addr == scdc_pkg::A_MAXPF)
            next_rdata = maxpf;
         else if (addr == scdc_pkg::A_SEGSZ)
            next_rdata = scdc_pkg::SEGSZ_RD;
         else if (addr == scdc_pkg::A_CHECK)
            next_rdata = check;
         else if (addr == scdc_pkg::A_STAT)
            next_rdata = {15'h0000, rej};
         else if (addr == scdc_pkg::A_CHIT)
            next_rdata = chit;
         else if (addr == scdc_pkg::A_PHIT)
            next_rdata = phit;
      end
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         ctrl  <= scdc_pkg::CTRL_RST;
         ahead <= scdc_pkg::AHEAD_RST;
         check <= scdc_pkg::CHECK_RST;
         maxpf <= scdc_pkg::MAXPF_RST;
         nseg  <= scdc_pkg::NSEG_RST;
         rej   <= 1'b0;
         rdata <= 16'h0000;
      end
      else
      begin
         ctrl  <= next_ctrl;
         ahead <= next_ahead;
         check <= next_check;
         maxpf <= next_maxpf;
         nseg  <= next_nseg;
         rej   <= next_rej;
         rdata <= next_rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // segment tags and lookup
   scdc_pkg::scdc_state_t state, next_state;
   logic [LW-1:0] seg_start [NS];
   logic [SW-1:0] seg_cnt [NS];
   logic [SW-1:0] seg_org [NS];
   logic [SW-1:0] seg_pfo [NS];
   logic [NS-1:0] seg_v, in_v, pf_v, ov_v;
   logic [LW-1:0] cur, clba, lst, lend, stride;
   logic [15:0]   rem, pf_n;
   logic [SW-1:0] seg_len, wptr, cptr, pend, hoff;
   logic [SW:0]   hsum;
   logic [IW-1:0] vic, aseg, hidx;
   logic          hit, cwr, adaptive_lookahead_ctrl_en, pf_ok, med_idle;

   // whole sectors per segment, buffer split evenly
   assign seg_len = SW'(BUF_BLK) / {7'h00, nseg};

   for (genvar g = 0; g < NS; g++)
   begin : g_seg
      logic [LW-1:0] d;
      assign d = cur - seg_start[g];
      assign in_v[g] = seg_v[g] && 5'(g) < nseg
                       && d < LW'(seg_cnt[g]);
      assign pf_v[g] = d >= LW'(seg_pfo[g]);
      assign ov_v[g] = seg_v[g] && (d < LW'(seg_cnt[g])
                       || seg_start[g] - cur < LW'(rem));
   end

   always_comb
   begin
      hit  = 1'b0;
      hidx = '0;
      for (int i = NS - 1; i >= 0; i--)
      begin
         // read cache off: only prefetched blocks may be served
         if (in_v[i] && (!rcd || pf_v[i]))
         begin
            hit  = 1'b1;
            hidx = IW'(i);
         end
      end
      hsum = {1'b0, seg_org[hidx]} + (SW + 1)'(cur - seg_start[hidx]);
      hoff = hsum >= {1'b0, seg_len} ? SW'(hsum - {1'b0, seg_len})
                                     : SW'(hsum);
   end

   assign pf_ok    = !dra && adaptive_lookahead_ctrl_en && maxpf != 16'h0000;
   assign med_idle = !med.rd && !med.wr;
   assign cmd_ready = state == scdc_pkg::S_IDLE;
   assign wr_ready  = state == scdc_pkg::S_WDATA && rem != 16'h0000
                      && pend < seg_len;

   ////////////////////////////////////////////////////////////////////////
   // command engine
   logic [LW-1:0] next_seg_start [NS];
   logic [SW-1:0] next_seg_cnt [NS];
   logic [SW-1:0] next_seg_org [NS];
   logic [SW-1:0] next_seg_pfo [NS];
   logic [NS-1:0] next_seg_v;
   logic [LW-1:0] next_cur, next_clba, next_lst, next_lend, next_stride;
   logic [15:0]   next_rem, next_pf_n, next_chit, next_phit;
   logic [SW-1:0] next_wptr, next_cptr, next_pend;
   logic [IW-1:0] next_vic, next_aseg;
   logic          next_cwr, next_adaptive_lookahead_ctrl, acc, wack;
   scdc_pkg::scdc_xfer_t next_xfer;
   scdc_pkg::scdc_med_t  next_med;

   function automatic logic [AW-1:0] badr(input logic [IW-1:0] s,
                                          input logic [SW-1:0] len,
                                          input logic [SW-1:0] off);
      badr = AW'(AW'(s) * AW'(len)) + AW'(off);
   endfunction

   always_comb
   begin
      next_state     = state;
      next_seg_start = seg_start;
      next_seg_cnt   = seg_cnt;
      next_seg_org   = seg_org;
      next_seg_pfo   = seg_pfo;
      next_seg_v     = seg_v;
      next_cur       = cur;
      next_clba      = clba;
      next_lst       = lst;
      next_lend      = lend;
      next_stride    = stride;
      next_rem       = rem;
      next_pf_n      = pf_n;
      next_chit      = chit;
      next_phit      = phit;
      next_wptr      = wptr;
      next_cptr      = cptr;
      next_pend      = pend;
      next_vic       = vic;
      next_aseg      = aseg;
      next_cwr       = cwr;
      next_adaptive_lookahead_ctrl      = adaptive_lookahead_ctrl_en;
      next_xfer      = '0;
      next_med       = med;
      acc            = wr_valid && wr_ready;
      wack           = med_ack && med.wr;
      if (med_ack)
      begin
         next_med.rd = 1'b0;
         next_med.wr = 1'b0;
      end
      case (state)
         scdc_pkg::S_IDLE:
            if (cmd_valid)
            begin
               next_cur = cmd.lba;
               next_rem = cmd.nblk;
               if (cmd.write)
               begin
                  next_cwr   = wce && !cmd.dpo;
                  next_state = scdc_pkg::S_WINV;
               end
               else
               begin
                  // contiguous, or same stride under interleave
                  next_adaptive_lookahead_ctrl   = cmd.lba == lend
                                || (cmd.swi
                                    && cmd.lba - lst == stride);
                  next_stride = cmd.lba - lst;
                  next_lst    = cmd.lba;
                  next_lend   = cmd.lba + LW'(cmd.nblk);
                  next_state  = scdc_pkg::S_HIT;
               end
            end
         scdc_pkg::S_HIT:
            if (rem == 16'h0000)
               next_state = scdc_pkg::S_IDLE;
            else if (hit)
            begin
               // cached run, possibly across segments, unpaced
               next_xfer.valid  = 1'b1;
               next_xfer.hit    = 1'b1;
               next_xfer.pf_hit = pf_v[hidx];
               next_xfer.lba    = cur;
               next_xfer.addr   = badr(hidx, seg_len, hoff);
               if (pf_v[hidx])
                  next_phit = phit + 16'h0001;
               else
                  next_chit = chit + 16'h0001;
               next_cur = cur + 1'b1;
               next_rem = rem - 16'h0001;
            end
            else
            begin
               // first uncached block: rest goes into one segment
               next_aseg = vic;
               next_vic  = {1'b0, vic} + 5'h01 >= nseg ? '0 : vic + 1'b1;
               next_seg_v[vic]     = 1'b1;
               next_seg_start[vic] = cur;
               next_seg_cnt[vic]   = '0;
               next_seg_org[vic]   = '0;
               next_seg_pfo[vic]   = '1;
               next_state = scdc_pkg::S_FETCH;
            end
         scdc_pkg::S_FETCH:
            if (med_ack)
            begin
               next_xfer.valid = 1'b1;
               next_xfer.paced = 1'b1;
               next_xfer.lba   = cur;
               next_xfer.addr  = med.addr;
               next_seg_cnt[aseg] = seg_cnt[aseg] + 1'b1;
               next_cur = cur + 1'b1;
               next_rem = rem - 16'h0001;
            end
            else if (med_idle)
            begin
               if (rem == 16'h0000)
               begin
                  next_seg_pfo[aseg] = seg_cnt[aseg];
                  next_pf_n  = 16'h0000;
                  next_state = pf_ok ? scdc_pkg::S_PREF
                                     : scdc_pkg::S_IDLE;
               end
               else if (seg_cnt[aseg] == seg_len)
               begin
                  // segment wraps to its start
                  next_seg_start[aseg] = cur;
                  next_seg_cnt[aseg]   = '0;
               end
               else
               begin
                  next_med.rd   = 1'b1;
                  next_med.lba  = cur;
                  next_med.addr = badr(aseg, seg_len, seg_cnt[aseg]);
               end
            end
         scdc_pkg::S_PREF:
            if (med_ack)
            begin
               next_seg_cnt[aseg] = seg_cnt[aseg] + 1'b1;
               next_cur  = cur + 1'b1;
               next_pf_n = pf_n + 16'h0001;
            end
            else if (med_idle)
            begin
               if (pf_n >= maxpf || seg_cnt[aseg] == seg_len
                   || cmd_valid
                   || (!disc && cur[CYL_W-1:0] == '0))
                  next_state = scdc_pkg::S_IDLE;
               else
               begin
                  next_med.rd   = 1'b1;
                  next_med.lba  = cur;
                  next_med.addr = badr(aseg, seg_len, seg_cnt[aseg]);
               end
            end
         scdc_pkg::S_WINV:
         begin
            // drop stale copies before the new data lands
            next_seg_v = seg_v & ~ov_v;
            next_aseg  = vic;
            next_vic   = {1'b0, vic} + 5'h01 >= nseg ? '0 : vic + 1'b1;
            next_seg_v[vic]     = cwr;
            next_seg_start[vic] = cur;
            next_seg_cnt[vic]   = '0;
            next_seg_org[vic]   = '0;
            next_seg_pfo[vic]   = '1;
            next_wptr  = '0;
            next_cptr  = '0;
            next_pend  = '0;
            next_clba  = cur;
            next_state = scdc_pkg::S_WDATA;
         end
         scdc_pkg::S_WDATA:
         begin
            if (acc)
            begin
               next_xfer.valid = 1'b1;
               next_xfer.lba   = cur;
               next_xfer.addr  = badr(aseg, seg_len, wptr);
               next_wptr = wptr + 1'b1 == seg_len ? '0 : wptr + 1'b1;
               if (seg_cnt[aseg] == seg_len)
               begin
                  // overwrite oldest, already committed block
                  next_seg_start[aseg] = seg_start[aseg] + 1'b1;
                  next_seg_org[aseg]   = next_wptr;
               end
               else
                  next_seg_cnt[aseg] = seg_cnt[aseg] + 1'b1;
               next_cur = cur + 1'b1;
               next_rem = rem - 16'h0001;
            end
            if (wack)
            begin
               next_clba = clba + 1'b1;
               next_cptr = cptr + 1'b1 == seg_len ? '0 : cptr + 1'b1;
            end
            next_pend = pend + SW'(acc) - SW'(wack);
            if (med_idle && pend != '0)
            begin
               next_med.wr   = 1'b1;
               next_med.lba  = clba;
               next_med.addr = badr(aseg, seg_len, cptr);
            end
            else if (med_idle && pend == '0 && rem == 16'h0000)
               next_state = scdc_pkg::S_IDLE;
         end
         default:
            next_state = scdc_pkg::S_IDLE;
      endcase
      if (nseg_wr)
      begin
         // new partition: every tag is void
         next_seg_v = '0;
         next_vic   = '0;
      end
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         state   <= scdc_pkg::S_IDLE;
         seg_v   <= '0;
         for (int i = 0; i < NS; i++)
         begin
            seg_start[i] <= '0;
            seg_cnt[i]   <= '0;
            seg_org[i]   <= '0;
            seg_pfo[i]   <= '0;
         end
         cur     <= '0;
         clba    <= '0;
         lst     <= '0;
         lend    <= '0;
         stride  <= '0;
         rem     <= '0;
         pf_n    <= '0;
         chit    <= '0;
         phit    <= '0;
         wptr    <= '0;
         cptr    <= '0;
         pend    <= '0;
         vic     <= '0;
         aseg    <= '0;
         cwr     <= 1'b0;
         adaptive_lookahead_ctrl_en <= 1'b1;
         xfer    <= '0;
         med     <= '0;
      end
      else
      begin
         state     <= next_state;
         seg_v     <= next_seg_v;
         seg_start <= next_seg_start;
         seg_cnt   <= next_seg_cnt;
         seg_org   <= next_seg_org;
         seg_pfo   <= next_seg_pfo;
         cur       <= next_cur;
         clba      <= next_clba;
         lst       <= next_lst;
         lend      <= next_lend;
         stride    <= next_stride;
         rem       <= next_rem;
         pf_n      <= next_pf_n;
         chit      <= next_chit;
         phit      <= next_phit;
         wptr      <= next_wptr;
         cptr      <= next_cptr;
         pend      <= next_pend;
         vic       <= next_vic;
         aseg      <= next_aseg;
         cwr       <= next_cwr;
         adaptive_lookahead_ctrl_en   <= next_adaptive_lookahead_ctrl;
         xfer      <= next_xfer;
         med       <= next_med;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   sequence s_size_rd;
      rd && addr == scdc_pkg::A_SEGSZ;
   endsequence
   sequence s_size_wr;
      wr && addr == scdc_pkg::A_SEGSZ && check[scdc_pkg::B_CHK];
   endsequence

   chk_nseg_range:
      assert property (nseg >= 5'h01 && nseg <= 5'h10)
      else $error("segment count out of range");
   chk_size_reads:
      assert property (s_size_rd |=> rdata == 16'hffff)
      else $error("size field not all ones");
   chk_size_reject:
      assert property (s_size_wr ##1 1'b1 |-> rej && $stable(nseg))
      else $error("size write not rejected");
   chk_hit_unpaced:
      assert property (xfer.valid && xfer.hit |-> !xfer.paced)
      else $error("hit transfer paced");
   chk_wr_stall:
      assert property (pend >= seg_len |-> !wr_ready ##1 pend <= seg_len)
      else $error("uncommitted block overwritten");
   chk_pf_limit:
      assert property (state == scdc_pkg::S_PREF && med_idle
                       && pf_n >= maxpf |=> state == scdc_pkg::S_IDLE)
      else $error("prefetch past maximum");
   chk_cyl_cross:
      assert property ($rose(med.rd) && state == scdc_pkg::S_PREF
                       |-> disc || med.lba[CYL_W-1:0] != '0)
      else $error("prefetch crossed cylinder");
   chk_contig_on:
      assert property (cmd_valid && cmd_ready && !cmd.write
                       && cmd.lba == lend |=> adaptive_lookahead_ctrl_en)
      else $error("look-ahead off on contiguous read");
   chk_read_ahead:
      assert property (state == scdc_pkg::S_PREF |-> !dra ##1 1'b1)
      else $error("prefetch with read-ahead disabled");
endmodule

/* tb/scdc_med_model.sv */
// medium side model: answers each held request after a set delay
`timescale 1ns/100ps
module scdc_med_model
(
   input  wire logic                clk,
   input  wire logic                nrst,
   input  wire scdc_pkg::scdc_med_t med,
   input  wire logic [3:0]          dly,
   output      logic                med_ack
);
   logic [3:0] cnt;
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         med_ack <= 1'b0;
         cnt     <= 4'h0;
      end
      else if (med_ack)
      begin
         med_ack <= 1'b0;
         cnt     <= 4'h0;
      end
      else if ((med.rd | med.wr) && cnt >= dly)
         med_ack <= 1'b1;
      else if (med.rd | med.wr)
         cnt <= cnt + 4'h1;
   end
endmodule

/* tb/test_scdc_cache.sv */
// bench of the segmented cache manager with a queue model of the tags
`timescale 1ns/100ps
module test_scdc_cache;
   logic                 clk = 1'b0;
   logic                 nrst = 1'b0;
   logic                 wr = 1'b0;
   logic                 rd = 1'b0;
   logic                 cmd_valid = 1'b0;
   logic                 wr_valid = 1'b0;
   logic                 med_ack;
   logic                 cmd_ready;
   logic                 wr_ready;
   logic [3:0]           addr = 4'h0;
   logic [3:0]           dly = 4'h0;
   logic [15:0]          wdata = 16'h0000;
   logic [15:0]          rdata;
   logic [31:0]          a;
   scdc_pkg::scdc_cmd_t  cmd = '0;
   scdc_pkg::scdc_xfer_t xfer;
   scdc_pkg::scdc_med_t  med;
   int                   n_mismatch = 0;
   int                   tests_run = 0;
   int                   cyc = 0;
   int                   seed = 16052;
   int                   v;
   bit                   rcd = 1'b0;
   int                   cache[$];
   int                   pfq[$];
   int                   nsv[5] = '{0, 17, 16, 1, 5};
   int                   blk = scdc_pkg::BUF_SMALL / scdc_pkg::BLK_BYTES;
   int                   nh = 0;
   int                   np = 0;
   bit                   dpo = 1'b1;
   logic [31:0]          loc[int];
   always #20 clk = ~clk;
   scdc_cache #(.LARGE_BUF(1'b0), .CYL_W(4)) DUT (.clk(clk), .nrst(nrst),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready),
      .wr_valid(wr_valid), .wr_ready(wr_ready), .xfer(xfer), .med(med),
      .med_ack(med_ack));
   scdc_med_model MED (.clk(clk), .nrst(nrst), .med(med), .dly(dly),
      .med_ack(med_ack));
   ////////////////////////////////////////////////////////////////////////
   task automatic complete_run;
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] got, exp);
      tests_run++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("[ERR] %s exp %h got %h", nm, exp, got);
      end
   endtask
   task automatic rg_wr(input logic [3:0] ad, input logic [15:0] d);
      @(posedge clk);
      addr <= ad; wdata <= d; wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rg_rd(input logic [3:0] ad, input logic [15:0] e);
      @(posedge clk);
      addr <= ad; rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk("rdata", {16'h0, rdata}, {16'h0, e});
   endtask
   // one command; collects each block moved and checks it against the model
   task automatic run(input logic [31:0] l, input int n, input bit w);
      int t; bit h; bit miss; bit pf;
      miss = 1'b0;
      dly <= 4'($unsigned($random(seed)) % 6);
      for (t = 0; !cmd_ready && t < 4000; t++) @(negedge clk);
      @(posedge clk);
      cmd_valid <= 1'b1; cmd <= '{l, n[15:0], w, w & dpo, 1'b0}; wr_valid <= w;
      @(posedge clk);
      cmd_valid <= 1'b0;
      for (int i = 0; i < n; i++)
      begin
         h = !w && !rcd && !miss && (l + i) inside {cache};
         miss = miss | !h;
         pf = h && (l + i) inside {pfq};
         for (t = 0; !xfer.valid && t < 2000; t++) @(negedge clk);
         chk("lba", xfer.lba, l + i);
         chk("hit", {31'h0, xfer.hit}, {31'h0, h});
         chk("pf_hit", {31'h0, xfer.pf_hit}, {31'h0, pf});
         if (h && !pf) chk("addr", {16'h0, xfer.addr}, loc[l + i]);
         chk("in_buf", {31'h0, xfer.addr < 16'(blk / v * v)}, 32'h1);
         loc[l + i] = {16'h0, xfer.addr};
         nh += int'(h && !pf);
         np += int'(pf);
         if (!w) chk("paced", {31'h0, xfer.paced}, {31'h0, !h});
         if (!h && !w) cache.push_back(l + i);
         @(negedge clk);
      end
      @(posedge clk) wr_valid <= 1'b0;
      $display("command at %h done", l);
   endtask
   ////////////////////////////////////////////////////////////////////////
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         n_mismatch++;
         complete_run();
      end
   end
   initial
   begin
      a = 32'($random(seed)) & 32'h00ff_fff0;
      repeat (8) @(posedge clk);
      nrst <= 1'b1;
      rg_rd(scdc_pkg::A_NSEG, 16'h0003);
      rg_rd(scdc_pkg::A_CTRL, 16'h0000);
      rg_rd(scdc_pkg::A_AHEAD, 16'h0000);
      rg_rd(scdc_pkg::A_MAXPF, 16'h0040);
      rg_rd(4'hf, 16'h0000);
      rg_wr(scdc_pkg::A_SEGSZ, 16'h1234);
      rg_rd(scdc_pkg::A_STAT, 16'h0000);
      rg_wr(scdc_pkg::A_CHECK, 16'h0002);
      rg_wr(scdc_pkg::A_SEGSZ, 16'h0001);
      rg_rd(scdc_pkg::A_STAT, 16'h0001);
      rg_rd(scdc_pkg::A_SEGSZ, 16'hffff);
      v = 3;
      foreach (nsv[i])
      begin
         rg_wr(scdc_pkg::A_NSEG, 16'(nsv[i]));
         if (nsv[i] >= 1 && nsv[i] <= 16) v = nsv[i];
         rg_rd(scdc_pkg::A_NSEG, 16'(v));
      end
      rg_wr(scdc_pkg::A_MAXPF, 16'h0000);
      run(a, 4, 1'b0);
      run(a, 4, 1'b0);
      run(a, 6, 1'b0);
      rg_wr(scdc_pkg::A_CTRL, 16'h0001);
      rcd = 1'b1;
      run(a, 2, 1'b0);
      rg_wr(scdc_pkg::A_CTRL, 16'h0000);
      rcd = 1'b0;
      run(a + 1, 1, 1'b1);
      cache = cache.find(x) with (x >= a + 4);
      run(a + 4, 2, 1'b0);
      run(a + 1, 1, 1'b0);
      rg_wr(scdc_pkg::A_NSEG, 16'h0003);
      v = 3;
      cache.delete();
      run(a + 4, 1, 1'b0);
      rg_wr(scdc_pkg::A_MAXPF, 16'h0002);
      run(a + 5, 1, 1'b0);
      pfq.push_back(a + 6);
      pfq.push_back(a + 7);
      cache.push_back(a + 6);
      cache.push_back(a + 7);
      run(a + 6, 2, 1'b0);
      rg_wr(scdc_pkg::A_CTRL, 16'h0004);
      dpo = 1'b0;
      run(a + 9, 1, 1'b1);
      cache.push_back(a + 9);
      run(a + 9, 1, 1'b0);
      rg_rd(scdc_pkg::A_CHIT, 16'(nh));
      rg_rd(scdc_pkg::A_PHIT, 16'(np));
      complete_run();
   end
endmodule
